// ---- inc/vpi_pkg.sv ----
// Constants and types shared by the vectored priority interrupt block
package vpi_pkg;

    localparam int NUM_LEVELS = 8;
    localparam int VEC_W = 3;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_MASK = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_MASK_SET = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_MASK_CLR = 5'h0C;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_VECTOR = 5'h14;
    localparam logic [ADDR_W-1:0] OFF_PENDING = 5'h18;
    localparam logic [ADDR_W-1:0] OFF_CMD = 5'h1C;

    // Field positions
    localparam int CTRL_IRE_BIT = 0;
    localparam int CTRL_ROT_BIT = 1;
    localparam int CMD_CLR_ALL_BIT = 0;
    localparam int CMD_CLR_LAST_BIT = 1;
    localparam int CMD_MASTER_BIT = 2;
    localparam int VEC_VALID_BIT = 7;
    localparam int VEC_ACC_BIT = 6;
    localparam int STAT_OVF_BIT = 7;

    // Reset values
    localparam logic [NUM_LEVELS-1:0] LEVELS_RST = 8'h00;
    localparam logic [NUM_LEVELS-1:0] MASK_RST = 8'h00;
    localparam logic [NUM_LEVELS-1:0] SYNC_IDLE = 8'hFF;
    localparam logic [VEC_W-1:0] STATUS_RST = 3'h0;
    localparam logic [VEC_W-1:0] VEC_RST = 3'h0;
    localparam logic [VEC_W-1:0] PTR_RST = 3'h7;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic valid;
        logic [VEC_W-1:0] vec;
    } enc_res_t;

endpackage

// ---- logic/prio_encoder.sv ----
// Static or rotating eight-level priority encoder
`timescale 1ns/1ps
`default_nettype none

module prio_encoder (
    input wire logic [vpi_pkg::NUM_LEVELS-1:0] active,
    input wire logic rotate,
    input wire logic [vpi_pkg::VEC_W-1:0] low_ptr,
    output var vpi_pkg::enc_res_t result
);

    logic [vpi_pkg::VEC_W-1:0] base;
    logic [vpi_pkg::VEC_W-1:0] idx;

    // Scan from lowest to highest priority; the last hit is the winner
    always_comb begin
        base = rotate ? low_ptr : 3'h0; // RULE_15 RULE_16
        idx = base;
        result.valid = |active;
        result.vec = vpi_pkg::VEC_RST;
        for (int k = 0; k < vpi_pkg::NUM_LEVELS; k++) begin
            idx = base + k[vpi_pkg::VEC_W-1:0];
            if (active[idx]) begin
                result.vec = idx; // RULE_05
            end
        end
    end

endmodule // prio_encoder

`default_nettype wire

// ---- logic/vectored_priority_interrupt.sv ----
// Vectored priority interrupt controller with mask, threshold and nesting support
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE_01: One active-low request input per level, each level maskable on its own.
// RULE_02: First stage catches each request and holds it until cleared.
// RULE_03: Second stage resamples caught requests on the system clock.
// RULE_04: Each stored request bit has its own clear.
// RULE_05: Priority encoder gives the binary index of the winning request.
// RULE_06: Stored requests are ANDed with mask enables before the encoder.
// RULE_07: Software enables or disables globally and sets or clears mask bits.
// RULE_08: Vector hold register keeps the last recognised vector.
// RULE_09: Held vector drives clearing of just the last recognised request.
// RULE_10: Clear the request in service, or clear all requests at once.
// RULE_11: Only requests above the threshold interrupt; lower ones stay pending. Here a vector equal to status also interrupts.
// RULE_12: Threshold loadable by software or set to serviced level plus one.
// RULE_13: On recognition status gets level plus one; comparator checks each vector.
// RULE_14: Processor saves status before service and writes it back afterwards.
// RULE_15: Static mode: fixed order, highest active level always wins.
// RULE_16: Rotating mode: pointer marks lowest level, moves to level just serviced.
// RULE_17: Eight request bits, set on a rising edge while the input is low.
// RULE_18: Candidate accepted when vector is greater than or equal to status.
// RULE_19: Interrupt output only when enabled and an unmasked request passes.
// RULE_20: Reset clears requests, mask, status and vector hold registers.
module vectored_priority_interrupt (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [vpi_pkg::NUM_LEVELS-1:0] req_n,
    input wire vpi_pkg::bus_req_t bus,
    output logic [vpi_pkg::DATA_W-1:0] rd_data,
    output logic irq_req
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [vpi_pkg::NUM_LEVELS-1:0] sync1_ff;
    logic [vpi_pkg::NUM_LEVELS-1:0] sync2_ff;
    logic [vpi_pkg::NUM_LEVELS-1:0] sync3_ff;
    logic [vpi_pkg::NUM_LEVELS-1:0] catch_ff;
    logic [vpi_pkg::NUM_LEVELS-1:0] req_ff;
    logic [vpi_pkg::NUM_LEVELS-1:0] mask_ff;
    logic [vpi_pkg::VEC_W-1:0] status_ff;
    logic ovf_ff;
    logic [vpi_pkg::VEC_W-1:0] vhold_ff;
    logic vce_ff;
    logic ire_ff;
    logic rot_ff;
    logic [vpi_pkg::VEC_W-1:0] ptr_ff;
    logic irq_ff;
    logic [vpi_pkg::DATA_W-1:0] rd_data_ff;

    logic [vpi_pkg::NUM_LEVELS-1:0] set_vec;
    logic [vpi_pkg::NUM_LEVELS-1:0] clr_vec;
    logic [vpi_pkg::NUM_LEVELS-1:0] masked;
    logic [vpi_pkg::VEC_W:0] incr;
    logic accept;
    logic wr_ctrl;
    logic wr_mask;
    logic wr_mask_set;
    logic wr_mask_clr;
    logic wr_status;
    logic wr_pending;
    logic wr_cmd;
    logic rd_vector;
    logic recognize;
    logic cmd_clr_all;
    logic cmd_clr_last;
    logic cmd_master;
    vpi_pkg::enc_res_t enc;

    localparam logic [vpi_pkg::NUM_LEVELS-1:0] LEVELS_ONE = 8'h01;

    function automatic logic [vpi_pkg::NUM_LEVELS-1:0] onehot(input logic [vpi_pkg::VEC_W-1:0] v);
        logic [vpi_pkg::NUM_LEVELS-1:0] r;
        r = LEVELS_ONE << v;
        return r;
    endfunction

    function automatic logic is_write(input vpi_pkg::bus_req_t b, input logic [vpi_pkg::ADDR_W-1:0] off);
        return b.wr && (b.addr == off);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    assign wr_ctrl = is_write(bus, vpi_pkg::OFF_CTRL);
    assign wr_mask = is_write(bus, vpi_pkg::OFF_MASK);
    assign wr_mask_set = is_write(bus, vpi_pkg::OFF_MASK_SET);
    assign wr_mask_clr = is_write(bus, vpi_pkg::OFF_MASK_CLR);
    assign wr_status = is_write(bus, vpi_pkg::OFF_STATUS);
    assign wr_pending = is_write(bus, vpi_pkg::OFF_PENDING);
    assign wr_cmd = is_write(bus, vpi_pkg::OFF_CMD);
    assign rd_vector = bus.rd && (bus.addr == vpi_pkg::OFF_VECTOR);
    assign recognize = rd_vector && enc.valid;
    assign cmd_clr_all = wr_cmd && bus.wdata[vpi_pkg::CMD_CLR_ALL_BIT];
    assign cmd_clr_last = wr_cmd && bus.wdata[vpi_pkg::CMD_CLR_LAST_BIT];
    assign cmd_master = wr_cmd && bus.wdata[vpi_pkg::CMD_MASTER_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Request capture and synchronisation

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sync1_ff <= vpi_pkg::SYNC_IDLE;
            sync2_ff <= vpi_pkg::SYNC_IDLE;
            sync3_ff <= vpi_pkg::SYNC_IDLE;
        end else begin
            sync1_ff <= req_n;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // A level counts as requesting once two synchronised samples agree low
    assign set_vec = ~sync2_ff & ~sync3_ff; // RULE_17 RULE_01

    // Per-bit clears from every clear source
    always_comb begin
        clr_vec = vpi_pkg::LEVELS_RST;
        if (cmd_clr_all || cmd_master) begin
            clr_vec = ~vpi_pkg::LEVELS_RST; // RULE_10
        end
        if (wr_pending) begin
            clr_vec = clr_vec | bus.wdata; // RULE_04
        end
        if (cmd_clr_last && vce_ff) begin
            clr_vec = clr_vec | onehot(vhold_ff); // RULE_09 RULE_10
        end
    end

    // New requests win over a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            catch_ff <= vpi_pkg::LEVELS_RST; // RULE_20
        end else begin
            catch_ff <= (catch_ff & ~clr_vec) | set_vec; // RULE_02 RULE_04
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            req_ff <= vpi_pkg::LEVELS_RST; // RULE_20
        end else begin
            req_ff <= catch_ff & ~clr_vec; // RULE_03
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mask, control and encoder

    always_ff @(posedge mclk) begin
        if (!reset_n || cmd_master) begin
            mask_ff <= vpi_pkg::MASK_RST; // RULE_20
        end else if (wr_mask) begin
            mask_ff <= bus.wdata; // RULE_07
        end else if (wr_mask_set) begin
            mask_ff <= mask_ff | bus.wdata; // RULE_07
        end else if (wr_mask_clr) begin
            mask_ff <= mask_ff & ~bus.wdata; // RULE_07
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ire_ff <= 1'b0;
            rot_ff <= 1'b0;
        end else if (cmd_master) begin
            ire_ff <= 1'b1;
            rot_ff <= 1'b0;
        end else if (wr_ctrl) begin
            ire_ff <= bus.wdata[vpi_pkg::CTRL_IRE_BIT]; // RULE_07
            rot_ff <= bus.wdata[vpi_pkg::CTRL_ROT_BIT];
        end
    end

    // A set mask bit inhibits its level
    assign masked = req_ff & ~mask_ff; // RULE_06

    prio_encoder u_enc (
        .active(masked),
        .rotate(rot_ff),
        .low_ptr(ptr_ff),
        .result(enc)
    );

    // Comparator: vector at or above status, and no overflow
    assign accept = (enc.vec >= status_ff) && !ovf_ff; // RULE_18 RULE_11

    ////////////////////////////////////////////////////////////////////////////
    // Status, vector hold and rotation pointer

    assign incr = {1'b0, enc.vec} + 4'h1; // RULE_13

    always_ff @(posedge mclk) begin
        if (!reset_n || cmd_master) begin
            status_ff <= vpi_pkg::STATUS_RST; // RULE_20
            ovf_ff <= 1'b0;
        end else if (wr_status) begin
            status_ff <= bus.wdata[vpi_pkg::VEC_W-1:0]; // RULE_12 RULE_14
            ovf_ff <= bus.wdata[vpi_pkg::STAT_OVF_BIT];
        end else if (recognize) begin
            status_ff <= incr[vpi_pkg::VEC_W-1:0]; // RULE_12 RULE_13
            ovf_ff <= incr[vpi_pkg::VEC_W];
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n || cmd_master) begin
            vhold_ff <= vpi_pkg::VEC_RST; // RULE_20
            vce_ff <= 1'b0;
        end else if (recognize) begin
            vhold_ff <= enc.vec; // RULE_08
            vce_ff <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n || cmd_master) begin
            ptr_ff <= vpi_pkg::PTR_RST;
        end else if (recognize && rot_ff) begin
            ptr_ff <= enc.vec; // RULE_16
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt output and read data

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= ire_ff && enc.valid && accept; // RULE_19 RULE_11
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rd_data_ff <= vpi_pkg::DATA_ZERO;
        end else if (bus.rd) begin
            rd_data_ff <= vpi_pkg::DATA_ZERO;
            case (bus.addr)
                vpi_pkg::OFF_CTRL: begin
                    rd_data_ff[vpi_pkg::CTRL_IRE_BIT] <= ire_ff;
                    rd_data_ff[vpi_pkg::CTRL_ROT_BIT] <= rot_ff;
                end
                vpi_pkg::OFF_MASK: begin
                    rd_data_ff <= mask_ff;
                end
                vpi_pkg::OFF_STATUS: begin
                    rd_data_ff[vpi_pkg::VEC_W-1:0] <= status_ff; // RULE_14
                    rd_data_ff[vpi_pkg::STAT_OVF_BIT] <= ovf_ff;
                end
                vpi_pkg::OFF_VECTOR: begin
                    rd_data_ff[vpi_pkg::VEC_W-1:0] <= enc.vec;
                    rd_data_ff[vpi_pkg::VEC_ACC_BIT] <= accept;
                    rd_data_ff[vpi_pkg::VEC_VALID_BIT] <= enc.valid;
                end
                vpi_pkg::OFF_PENDING: begin
                    rd_data_ff <= req_ff;
                end
                default: begin
                    rd_data_ff <= vpi_pkg::DATA_ZERO;
                end
            endcase
        end else begin
            rd_data_ff <= vpi_pkg::DATA_ZERO;
        end
    end

    assign rd_data = rd_data_ff;
    assign irq_req = irq_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    chk_irq_enable_gate: assert property (!ire_ff |=> !irq_req) // RULE_19
        else $error("irq raised while globally disabled");

    chk_irq_needs_pass: assert property (irq_req |-> $past(enc.valid) && $past(accept)) // RULE_11
        else $error("irq raised without accepted request");

    chk_mask_excludes: assert property (enc.valid |-> !mask_ff[enc.vec] && req_ff[enc.vec]) // RULE_06
        else $error("encoder picked a masked or idle level");

    chk_static_highest: assert property (!rot_ff && enc.valid |-> (masked >> enc.vec) == LEVELS_ONE) // RULE_15
        else $error("static encoder missed a higher level");

    chk_status_incr: assert property (recognize |=> status_ff == $past(enc.vec) + 3'h1) // RULE_13
        else $error("status not loaded with vector plus one");

    chk_status_ovf: assert property (recognize && enc.vec == 3'h7 |=> ovf_ff ##1 !irq_req) // RULE_12
        else $error("top vector read did not block interrupts");

    chk_vhold_load: assert property (recognize |=> vhold_ff == $past(enc.vec) && vce_ff) // RULE_08
        else $error("vector hold not loaded on recognition");

    chk_rot_pointer: assert property (recognize && rot_ff |=> ptr_ff == $past(enc.vec)) // RULE_16
        else $error("rotation pointer did not follow serviced level");

    chk_catch_hold: assert property (1'b1 |=> (($past(catch_ff) & ~$past(clr_vec)) & ~catch_ff) == 8'h00) // RULE_02
        else $error("caught request lost without a clear");

    chk_capture_low: assert property ((!req_n[1] && !clr_vec[1])[*5] |=> catch_ff[1] && req_ff[1]) // RULE_17
        else $error("held low request not captured");

    chk_clear_all: assert property (cmd_clr_all && set_vec == 8'h00 |=> req_ff == 8'h00 && catch_ff == 8'h00) // RULE_10
        else $error("clear all left a request");

    chk_clear_last: assert property (cmd_clr_last && vce_ff && !set_vec[vhold_ff]
        |=> !req_ff[$past(vhold_ff)] && !catch_ff[$past(vhold_ff)]) // RULE_09
        else $error("last vector request not cleared");

    chk_clear_pending: assert property (wr_pending && (bus.wdata & set_vec) == 8'h00 // RULE_04
        |=> (catch_ff & $past(bus.wdata)) == 8'h00 && (req_ff & $past(bus.wdata)) == 8'h00)
        else $error("pending clear left a request");

    chk_irq_follows: assert property (ire_ff && enc.valid && accept |=> irq_req) // RULE_19
        else $error("accepted request raised no irq");

    chk_master_clear: assert property (cmd_master |=> mask_ff == vpi_pkg::MASK_RST && !vce_ff && ire_ff // RULE_07
        && status_ff == vpi_pkg::STATUS_RST && !ovf_ff && !rot_ff && ptr_ff == vpi_pkg::PTR_RST)
        else $error("master clear left state behind");

    // Levels reordered so that bit 0 is the rotation's lowest level
    logic [2*vpi_pkg::NUM_LEVELS-1:0] rot_pair;
    logic [vpi_pkg::VEC_W-1:0] win_rel;
    assign rot_pair = {masked, masked} >> ptr_ff;
    assign win_rel = enc.vec - ptr_ff;

    chk_rot_highest: assert property (rot_ff && enc.valid |-> (rot_pair[7:0] >> win_rel) == LEVELS_ONE) // RULE_16
        else $error("rotating encoder missed a higher level");

    cov_recognize: cover property (recognize ##1 irq_req);
    cov_irq_rise: cover property (!irq_req ##1 irq_req);
    cov_rotate_read: cover property (rot_ff && recognize);
    cov_clear_last: cover property (cmd_clr_last && vce_ff);

endmodule // vectored_priority_interrupt

`default_nettype wire

// ---- verif/periph_model.sv ----
// Peripheral model that pulls request lines low for a fixed number of cycles
`timescale 1ns/1ps
`default_nettype none

module periph_model #(
    parameter int HOLD_CYC = 6
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [vpi_pkg::NUM_LEVELS-1:0] fire,
    output logic [vpi_pkg::NUM_LEVELS-1:0] req_n
);
    logic [vpi_pkg::NUM_LEVELS-1:0] pulled_ff;
    int hold_ff;

    // Lines idle high; a fired level is held low long enough to be caught, then let go
    assign req_n = ~pulled_ff;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pulled_ff <= '0;
            hold_ff <= 0;
        end else if (fire != '0) begin
            pulled_ff <= pulled_ff | fire;
            hold_ff <= HOLD_CYC;
        end else if (hold_ff > 1) begin
            hold_ff <= hold_ff - 1;
        end else begin
            pulled_ff <= '0;
            hold_ff <= 0;
        end
    end
endmodule // periph_model

`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the vectored priority interrupt block
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic mclk;
    logic reset_n;
    logic [vpi_pkg::NUM_LEVELS-1:0] req_n;
    logic [vpi_pkg::NUM_LEVELS-1:0] fire;
    vpi_pkg::bus_req_t bus_s;
    logic [vpi_pkg::DATA_W-1:0] rd_data;
    logic irq_req;
    int miscompares;
    int comparisons;

    vectored_priority_interrupt vectored_priority_interrupt_inst (
        .mclk(mclk), .reset_n(reset_n), .req_n(req_n), .bus(bus_s), .rd_data(rd_data), .irq_req(irq_req));
    periph_model #(.HOLD_CYC(6)) periph_model_inst (.mclk(mclk), .reset_n(reset_n), .fire(fire), .req_n(req_n));

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic fail(input string msg);
        miscompares++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
        comparisons++;
        if (got !== exp) fail(msg);
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus_s <= {a, d, 1'b1, 1'b0};
        @(posedge mclk);
        bus_s.wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp, input string msg);
        @(posedge mclk);
        bus_s <= {a, vpi_pkg::DATA_ZERO, 1'b0, 1'b1};
        @(posedge mclk);
        bus_s.rd <= 1'b0;
        #1;
        chk8(rd_data, exp, msg);
    endtask

    // Lets a registered change settle, then waits a bounded time for the level
    task automatic chk_irq(input logic exp, input string msg);
        int n;
        repeat (3) @(posedge mclk);
        #1;
        for (n = 0; n < 10 && irq_req !== exp; n++) begin
            @(posedge mclk);
            #1;
        end
        comparisons++;
        if (irq_req !== exp) fail(msg);
    endtask

    task automatic raise(input logic [7:0] lv);
        @(posedge mclk);
        fire <= lv;
        @(posedge mclk);
        fire <= 8'h00;
        repeat (12) @(posedge mclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    initial begin
        reset_n = 1'b0;
        fire = 8'h00;
        bus_s = '0;
        miscompares = 0;
        comparisons = 0;
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        rd_chk(vpi_pkg::OFF_CTRL, 8'h00, "ctrl after reset");
        rd_chk(vpi_pkg::OFF_MASK, 8'h00, "mask after reset");
        rd_chk(vpi_pkg::OFF_STATUS, 8'h00, "status after reset");
        rd_chk(vpi_pkg::OFF_PENDING, 8'h00, "pending after reset");
        rd_chk(5'h02, 8'h00, "unmapped read");
        chk_irq(1'b0, "irq after reset");
        // Two levels at once, still held after the lines rise
        raise(8'h24);
        rd_chk(vpi_pkg::OFF_PENDING, 8'h24, "caught requests");
        chk_irq(1'b0, "irq while globally disabled");
        wr(vpi_pkg::OFF_CTRL, 8'h01);
        chk_irq(1'b1, "irq once enabled");
        rd_chk(vpi_pkg::OFF_VECTOR, 8'hC5, "highest level wins");
        rd_chk(vpi_pkg::OFF_STATUS, 8'h06, "status is level plus one");
        chk_irq(1'b0, "lower level fenced off");
        wr(vpi_pkg::OFF_CMD, 8'h02);
        rd_chk(vpi_pkg::OFF_PENDING, 8'h04, "clear last vector only");
        wr(vpi_pkg::OFF_STATUS, 8'h02);
        chk_irq(1'b1, "vector equal to threshold");
        wr(vpi_pkg::OFF_STATUS, 8'h03);
        chk_irq(1'b0, "vector below threshold");
        wr(vpi_pkg::OFF_STATUS, 8'h00);
        wr(vpi_pkg::OFF_MASK_SET, 8'h04);
        rd_chk(vpi_pkg::OFF_MASK, 8'h04, "mask bit set");
        chk_irq(1'b0, "masked level");
        wr(vpi_pkg::OFF_MASK_CLR, 8'h04);
        chk_irq(1'b1, "unmasked level");
        wr(vpi_pkg::OFF_CTRL, 8'h00);
        chk_irq(1'b0, "global disable");
        // Selective clear by data, then the top level overflows the status
        raise(8'h8A);
        wr(vpi_pkg::OFF_PENDING, 8'h02);
        rd_chk(vpi_pkg::OFF_PENDING, 8'h8C, "clear one pending bit");
        wr(vpi_pkg::OFF_CTRL, 8'h01);
        rd_chk(vpi_pkg::OFF_VECTOR, 8'hC7, "top level vector");
        rd_chk(vpi_pkg::OFF_STATUS, 8'h80, "status overflow");
        chk_irq(1'b0, "overflow blocks all");
        wr(vpi_pkg::OFF_CMD, 8'h01);
        rd_chk(vpi_pkg::OFF_PENDING, 8'h00, "clear all requests");
        wr(vpi_pkg::OFF_MASK_SET, 8'hFF);
        wr(vpi_pkg::OFF_CMD, 8'h04);
        rd_chk(vpi_pkg::OFF_MASK, 8'h00, "master clear mask");
        rd_chk(vpi_pkg::OFF_CTRL, 8'h01, "master clear enables");
        // Rotating order: the serviced level becomes the lowest
        wr(vpi_pkg::OFF_CTRL, 8'h03);
        raise(8'h42);
        rd_chk(vpi_pkg::OFF_VECTOR, 8'hC6, "rotate first winner");
        wr(vpi_pkg::OFF_STATUS, 8'h00);
        rd_chk(vpi_pkg::OFF_VECTOR, 8'hC1, "rotate pointer moved");
        wr(vpi_pkg::OFF_CMD, 8'h02);
        rd_chk(vpi_pkg::OFF_PENDING, 8'h40, "clear last in rotate mode");
        complete_run();
    end
endmodule // testbench

`default_nettype wire
